// ==== hdl/eitc_timer.sv ====
// Purpose: event interval timer with CAMAC command slave
// Assumes: straps and event strobe asynchronous; dataway synchronous
// Notes:   sample clock approximated here from ref_clk_i ticks; fast value comes in on toe_fast_i
`timescale 1ns/1ns
`default_nettype none
module eitc_timer #(
   parameter int CNT_W = eitc_pkg::CNT_W
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  event_b_i,
   input  wire logic                  freq_strap_low_i,
   input  wire logic                  freq_strap_high_i,
   input  wire logic                  init_z_i,
   input  wire eitc_pkg::eitc_dw_req_t dw_req_i,
   input  wire logic [7:0]            toe_sample_i,
   input  wire logic [2:0]            toe_fast_i,
   output eitc_pkg::eitc_dw_rsp_t     dw_rsp_o,
   output logic                       lam_o
);
   // ==================================================================
   // state
   typedef struct packed {
      logic [1:0]            ev_s;
      logic [1:0]            sl_s;
      logic [1:0]            sh_s;
      logic                  ev_d;
      eitc_pkg::eitc_state_t st;
      logic [CNT_W-1:0]      interval_count;
      logic [2:0]            div;
      logic [eitc_pkg::HOLD_W-1:0] hold;
      logic [15:0]           reg0;
      logic [15:0]           reg1;
      logic                  flag;
      logic                  en;
      logic                  first;
      eitc_pkg::eitc_dw_rsp_t rsp;
   } eitc_regs_t;

   eitc_regs_t r;
   eitc_regs_t next_r;

   // ==================================================================
   // command decode
   function automatic eitc_pkg::eitc_cmd_t decode(
      input logic [4:0] f,
      input logic [3:0] a
   );
      eitc_pkg::eitc_cmd_t c;
      c = eitc_pkg::CMD_NONE;
      if (f == eitc_pkg::F_READ && (a == eitc_pkg::A_REG0 ||
          a == eitc_pkg::A_REG1 || a == eitc_pkg::A_REG2)) begin
         c = eitc_pkg::CMD_RD;
      end else if (f == eitc_pkg::F_TEST && a == eitc_pkg::A_CTL) begin
         c = eitc_pkg::CMD_TEST;
      end else if (f == eitc_pkg::F_RESET && a == eitc_pkg::A_CTL) begin
         c = eitc_pkg::CMD_RESET;
      end else if (f == eitc_pkg::F_CLEAR && a == eitc_pkg::A_REG0) begin
         c = eitc_pkg::CMD_CLEAR;
      end else if (f == eitc_pkg::F_MASK && a == eitc_pkg::A_REG0) begin
         c = eitc_pkg::CMD_MASK;
      end else if (f == eitc_pkg::F_UNMASK && a == eitc_pkg::A_REG0) begin
         c = eitc_pkg::CMD_UNMASK;
      end
      return c;
   endfunction : decode

   eitc_pkg::eitc_cmd_t cmd;
   logic                ev_fall;
   logic                tick;
   logic [2:0]          div_max;
   logic [7:0]          reg2;
   logic                flag_set;

   // ==================================================================
   // next state
   always_comb begin
      next_r    = r;
      flag_set  = 1'b0;
      cmd       = dw_req_i.strobe ? decode(dw_req_i.func, dw_req_i.sub)
                                  : eitc_pkg::CMD_NONE;
      next_r.ev_s = {r.ev_s[0], event_b_i};
      next_r.sl_s = {r.sl_s[0], freq_strap_low_i};
      next_r.sh_s = {r.sh_s[0], freq_strap_high_i};
      next_r.ev_d = r.ev_s[1];
      ev_fall   = r.ev_d & ~r.ev_s[1];
      // strap fitted reads 0: both fitted 4 MHz
      case ({r.sh_s[1], r.sl_s[1]})
         2'b00:   div_max = eitc_pkg::DIV4;
         2'b01:   div_max = eitc_pkg::DIV8;
         default: div_max = eitc_pkg::DIV16;
      endcase
      // sample tick approximated from the reference clock
      tick       = (r.div >= div_max);
      next_r.div = tick ? 3'h0 : r.div + 3'h1;
      reg2 = 8'h00;
      reg2[eitc_pkg::REG2_FLAG]  = r.flag;
      reg2[eitc_pkg::REG2_EN]    = r.en;
      reg2[eitc_pkg::REG2_STRL]  = r.sl_s[1];
      reg2[eitc_pkg::REG2_STRH]  = r.sh_s[1];
      reg2[eitc_pkg::REG2_FIRST] = r.first;

      case (r.st)
         eitc_pkg::ST_IDLE: begin
            if (ev_fall) begin
               next_r.first = 1'b1;
               next_r.st    = eitc_pkg::ST_HOLD;
               next_r.hold  = '0;
            end
         end
         eitc_pkg::ST_RUN: begin
            if (ev_fall) begin
               next_r.st   = eitc_pkg::ST_HOLD;
               next_r.hold = '0;
            end else if (tick) begin
               // wraps naturally at all ones
               next_r.interval_count = r.interval_count + 1'b1;
            end
         end
         eitc_pkg::ST_HOLD: begin
            next_r.hold = r.hold + 1'b1;
            if (r.hold == '0) begin
               next_r.reg0 = {toe_sample_i[3:0], 1'b0, toe_fast_i,
                              r.interval_count[23:16]};
               next_r.reg1 = r.interval_count[15:0];
            end
            if (r.hold == eitc_pkg::HOLD_W'(eitc_pkg::HOLD_CYC - 1)) begin
               next_r.interval_count = '0;
               next_r.st   = eitc_pkg::ST_RUN;
               next_r.flag = 1'b1;
               flag_set    = 1'b1;
            end
         end
         default: next_r.st = eitc_pkg::ST_IDLE;
      endcase

      next_r.rsp = '0;
      if (cmd != eitc_pkg::CMD_NONE) begin
         next_r.rsp.q = 1'b1;
         next_r.rsp.x = 1'b1;
      end
      case (cmd)
         eitc_pkg::CMD_RD: begin
            if (dw_req_i.sub == eitc_pkg::A_REG0) begin
               next_r.rsp.rdata = r.reg0;
            end else if (dw_req_i.sub == eitc_pkg::A_REG1) begin
               next_r.rsp.rdata = r.reg1;
            end else begin
               next_r.rsp.rdata = {8'h00, reg2};
            end
            if (dw_req_i.sub != eitc_pkg::A_REG2) begin
               // a set in the same cycle survives the clear
               next_r.flag = flag_set;
            end
         end
         eitc_pkg::CMD_TEST:   next_r.rsp.q = r.flag & r.en;
         eitc_pkg::CMD_CLEAR:  next_r.flag = flag_set;
         eitc_pkg::CMD_MASK:   next_r.en = 1'b0;
         eitc_pkg::CMD_UNMASK: next_r.en = 1'b1;
         default: ;
      endcase
      if (cmd == eitc_pkg::CMD_RESET || init_z_i) begin
         next_r.st             = eitc_pkg::ST_IDLE;
         next_r.interval_count = '0;
         next_r.flag           = 1'b0;
         next_r.en             = 1'b0;
         next_r.first          = 1'b0;
         next_r.hold           = '0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign dw_rsp_o = r.rsp;
   assign lam_o    = r.flag & r.en;

   // ==================================================================
   // checks
   chk_lam_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      lam_o == (r.flag && r.en)) else $error("lam gate");
   chk_hold_len: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (r.st == eitc_pkg::ST_RUN && ev_fall && !init_z_i && !dw_req_i.strobe)
      |=> (r.st == eitc_pkg::ST_HOLD)[*8]) else $error("hold");
   chk_flag_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (r.st == eitc_pkg::ST_HOLD && r.hold == '0 && !init_z_i
       && !dw_req_i.strobe)
      |-> ##[1:60] r.flag) else $error("flag");
   chk_idle_still: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      r.st == eitc_pkg::ST_IDLE |-> r.interval_count == '0)
      else $error("idle count");
   chk_reset_cmd: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      init_z_i |=> (!r.flag && !r.en && !r.first)) else $error("rst");
   chk_qx_resp: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (dw_req_i.strobe && cmd != eitc_pkg::CMD_NONE) |=> dw_rsp_o.x)
      else $error("x");
   chk_unknown_cmd: assert property (@(posedge ref_clk_i)
      disable iff (!rst_b_i)
      (cmd == eitc_pkg::CMD_NONE) |=> !dw_rsp_o.x) else $error("x2");
   chk_mask_cmd: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (cmd == eitc_pkg::CMD_MASK && !init_z_i) |=> !r.en)
      else $error("mask");
   chk_count_clear: assert property (@(posedge ref_clk_i)
      disable iff (!rst_b_i)
      ($past(r.st) == eitc_pkg::ST_HOLD && r.st == eitc_pkg::ST_RUN)
      |-> r.interval_count == '0) else $error("clear");
   chk_flag_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (r.flag && cmd == eitc_pkg::CMD_NONE && !init_z_i) |=> r.flag)
      else $error("keep");

   cov_event: cover property (@(posedge ref_clk_i) ev_fall);
   cov_lam:   cover property (@(posedge ref_clk_i) lam_o);
   cov_read:  cover property (@(posedge ref_clk_i) cmd == eitc_pkg::CMD_RD);
   cov_wrap:  cover property (@(posedge ref_clk_i)
      r.interval_count == {CNT_W{1'b1}} && tick);
endmodule : eitc_timer
`default_nettype wire

// ==== hdl/eitc_pkg.sv ====
// Purpose: constants and carrier types for the event interval timer
// Assumes: 50 MHz reference clock, CAMAC dataway signals already sampled
// Notes:   Overview list below
//
// Overview of operation
// - 24-bit up-counter of six 4-bit stages
// - counter wraps to zero at maximum
// - counting starts only after first event
// - 1 us hold after strobe fall, capture
// - bits 23:16 low byte reg0, 15:0 reg1
// - clear counter then re-enable after capture
// - decode exactly eight function/subaddress commands
// - F0 A0/A1/A2 returns status registers
// - look-at-me flag set 1 us after strobe
// - flag cleared by reg0/reg1 read, F10A0, reset
// - reset and F24A0 mask, F26A0 unmask
// - request out only when flag and enable
// - reg2 bit0 flag, bit1 mask enable
// - F8A15 reports flag AND enable
// - F9A15 or Z performs board reset
// - X for every recognised command, Q too except F8A15
// - reg0 15:12 sample, 10:8 fast, 11 zero
// - reg2 bit4 first event, bits 3:2 straps
// - straps select 4, 8 or 16 MHz
package eitc_pkg;
   localparam int CLK_HZ        = 50_000_000;
   localparam int HOLD_NS       = 1000;
   // longest time for the hold rounds down
   localparam int HOLD_CYC      = HOLD_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int CNT_W         = 24;
   localparam int STAGE_W       = 4;
   localparam int HOLD_W        = 8;
   // sample clock dividers from 32 MHz base: 16, 8, 4 MHz
   localparam logic [2:0] DIV16 = 3'h1;
   localparam logic [2:0] DIV8  = 3'h3;
   localparam logic [2:0] DIV4  = 3'h7;

   localparam logic [4:0] F_READ   = 5'h00;
   localparam logic [4:0] F_TEST   = 5'h08;
   localparam logic [4:0] F_RESET  = 5'h09;
   localparam logic [4:0] F_CLEAR  = 5'h0A;
   localparam logic [4:0] F_MASK   = 5'h18;
   localparam logic [4:0] F_UNMASK = 5'h1A;
   localparam logic [3:0] A_REG0   = 4'h0;
   localparam logic [3:0] A_REG1   = 4'h1;
   localparam logic [3:0] A_REG2   = 4'h2;
   localparam logic [3:0] A_CTL    = 4'hF;

   localparam int REG2_FLAG  = 0;
   localparam int REG2_EN    = 1;
   localparam int REG2_STRL  = 2;
   localparam int REG2_STRH  = 3;
   localparam int REG2_FIRST = 4;

   typedef enum logic [2:0] {
      CMD_NONE   = 3'h0,
      CMD_RD     = 3'h1,
      CMD_TEST   = 3'h2,
      CMD_RESET  = 3'h3,
      CMD_CLEAR  = 3'h4,
      CMD_MASK   = 3'h5,
      CMD_UNMASK = 3'h6
   } eitc_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_HOLD = 2'h2
   } eitc_state_t;

   // one dataway cycle as presented to the block
   typedef struct packed {
      logic       strobe;
      logic [4:0] func;
      logic [3:0] sub;
   } eitc_dw_req_t;

   typedef struct packed {
      logic [15:0] rdata;
      logic        q;
      logic        x;
   } eitc_dw_rsp_t;
endpackage : eitc_pkg

// ==== tb/eitc_ctl_model.sv ====
// Purpose: crate controller model issuing dataway commands
// Assumes: block answers one cycle after the command strobe
// Notes:   requests change on falling edges only
`timescale 1ns/1ns
`default_nettype none
module eitc_ctl_model (
   input  wire logic                   ref_clk_i,
   output var eitc_pkg::eitc_dw_req_t  dw_req_o,
   input  wire eitc_pkg::eitc_dw_rsp_t dw_rsp_i
);
   eitc_pkg::eitc_dw_rsp_t rsp;

   initial dw_req_o = '0;

   // held over one rising edge; the answer stands in the cycle after
   task automatic cmd(input logic [4:0] f, input logic [3:0] a);
      @(negedge ref_clk_i);
      dw_req_o = '{strobe: 1'b1, func: f, sub: a};
      @(negedge ref_clk_i);
      // released lines show garbage, not the old command
      dw_req_o = '{strobe: 1'b0, func: ~f, sub: ~a};
      rsp = dw_rsp_i;
   endtask : cmd
endmodule : eitc_ctl_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the event interval timer
// Assumes: answers come one cycle after a command strobe
// Notes:   random intervals and time-of-event values, fixed seed
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic                   ref_clk_i;
   logic                   rst_b_i;
   logic                   event_b_i;
   logic                   lo;
   logic                   hi;
   logic                   init_z_i;
   logic [7:0]             toe_s;
   logic [2:0]             toe_f;
   eitc_pkg::eitc_dw_req_t req;
   eitc_pkg::eitc_dw_rsp_t rsp;
   logic                   lam;
   logic [31:0]            seed;
   logic [31:0]            r;
   longint                 last_fall;
   longint                 span;
   int                     fails;
   int                     comparisons;
   int                     e;
   int                     d;
   logic [1:0]             nxt [3];

   eitc_timer i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .event_b_i(event_b_i), .freq_strap_low_i(lo),
      .freq_strap_high_i(hi), .init_z_i(init_z_i), .dw_req_i(req),
      .toe_sample_i(toe_s), .toe_fast_i(toe_f), .dw_rsp_o(rsp),
      .lam_o(lam));
   eitc_ctl_model i_ctl (.ref_clk_i(ref_clk_i), .dw_req_o(req),
      .dw_rsp_i(rsp));

   // =====================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // reference cycles per sample tick
   function automatic int div(input logic l, input logic h);
      return ({h, l} == 2'b00) ? 8 : ({h, l} == 2'b01) ? 4 : 2;
   endfunction : div

   function automatic logic [15:0] r2(input logic f, en, fl);
      return {11'h000, f, hi, lo, en, fl};
   endfunction : r2

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t ns: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cmd(input logic [4:0] f, input logic [3:0] a,
                      input logic [1:0] qx, input logic [15:0] dat);
      i_ctl.cmd(f, a);
      chk({14'h0000, i_ctl.rsp.q, i_ctl.rsp.x}, {14'h0000, qx});
      if (qx[0] && f === eitc_pkg::F_READ)
         chk(i_ctl.rsp.rdata, dat);
   endtask : cmd

   // low pulse of 100 ns; straps change while the counter is held
   task automatic pulse(input logic nlo, input logic nhi);
      @(negedge ref_clk_i);
      event_b_i = 1'b0;
      span = ($time - last_fall) / 20;
      last_fall = $time;
      repeat (5) @(negedge ref_clk_i);
      event_b_i = 1'b1;
      lo = nlo;
      hi = nhi;
      repeat (55) @(negedge ref_clk_i);
   endtask : pulse

   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // =====================================
   // stimulus
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      #1_000_000;
      fails++;
      end_of_test();
   end

   initial begin
      seed = 32'h000034D2;
      {rst_b_i, init_z_i, lo, hi, event_b_i} = 5'h03;
      {toe_s, toe_f} = 11'h000;
      {fails, comparisons, last_fall} = '0;
      nxt = '{2'h2, 2'h0, 2'h1};
      repeat (5) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      // straps need two edges through their synchroniser
      repeat (2) @(negedge ref_clk_i);
      cmd(eitc_pkg::F_READ, eitc_pkg::A_REG2, 2'h3, r2(0, 0, 0));
      pulse(1'b0, 1'b1);
      cmd(eitc_pkg::F_READ, eitc_pkg::A_REG2, 2'h3, r2(1, 0, 1));
      chk(lam, 1'b0);
      cmd(eitc_pkg::F_TEST, eitc_pkg::A_CTL, 2'h1, 16'h0000);
      cmd(eitc_pkg::F_UNMASK, eitc_pkg::A_REG0, 2'h3, 16'h0000);
      chk(lam, 1'b1);
      cmd(eitc_pkg::F_TEST, eitc_pkg::A_CTL, 2'h3, 16'h0000);
      cmd(eitc_pkg::F_READ, eitc_pkg::A_REG1, 2'h3, 16'h0000);
      chk(lam, 1'b0);
      for (int k = 0; k < 3; k++) begin
         d = div(lo, hi);
         r = rnd();
         toe_s = r[7:0];
         toe_f = r[10:8];
         repeat (200 + r[19:11]) @(negedge ref_clk_i);
         pulse(nxt[k][1], nxt[k][0]);
         chk(lam, 1'b1);
         i_ctl.cmd(eitc_pkg::F_READ, eitc_pkg::A_REG1);
         e = int'((span - 50) / d);
         r = {16'h0000, i_ctl.rsp.rdata};
         chk(16'(r + 2 >= e && r <= e + 2), 16'h0001);
         cmd(eitc_pkg::F_READ, eitc_pkg::A_REG0, 2'h3,
             {toe_s[3:0], 1'b0, toe_f, 8'h00});
         chk(lam, 1'b0);
      end
      pulse(lo, hi);
      cmd(eitc_pkg::F_CLEAR, eitc_pkg::A_REG0, 2'h3, 16'h0000);
      cmd(eitc_pkg::F_READ, eitc_pkg::A_REG2, 2'h3, r2(1, 1, 0));
      cmd(eitc_pkg::F_MASK, eitc_pkg::A_REG0, 2'h3, 16'h0000);
      repeat (4) begin
         r = rnd();
         cmd({r[4:2], 2'h3}, r[8:5], 2'h0, 16'h0000);
      end
      cmd(eitc_pkg::F_UNMASK, 4'h1, 2'h0, 16'h0000);
      cmd(eitc_pkg::F_READ, eitc_pkg::A_REG2, 2'h3, r2(1, 0, 0));
      pulse(lo, hi);
      cmd(eitc_pkg::F_RESET, eitc_pkg::A_CTL, 2'h3, 16'h0000);
      cmd(eitc_pkg::F_READ, eitc_pkg::A_REG2, 2'h3, r2(0, 0, 0));
      cmd(eitc_pkg::F_UNMASK, eitc_pkg::A_REG0, 2'h3, 16'h0000);
      pulse(lo, hi);
      chk(lam, 1'b1);
      init_z_i = 1'b1;
      @(negedge ref_clk_i);
      init_z_i = 1'b0;
      chk(lam, 1'b0);
      cmd(eitc_pkg::F_READ, eitc_pkg::A_REG2, 2'h3, r2(0, 0, 0));
      end_of_test();
   end
endmodule : tb
`default_nettype wire
